// File: common/cfgr_pkg.sv
// Operation
// RULE1 - A set select bit adds its input to the conversion cycle (temp 14, remote 13..12, sense 11..8, inputs 7..0).
// RULE2 - Inputs whose select bit is zero are skipped during the conversion cycle.
// RULE3 - Each current loop has its own 4-bit ramp field (loop 4 at 15..12 to loop 1 at 3..0) resetting to 0010.
// RULE4 - Ramp codes 0000..1010 give settling times 0.8 to 28.8 ms and any other code is invalid.
// RULE5 - A DAC output is in synchronous update mode when its sync bit is one (aux 4..1 at 7..4, main 4..1 at 3..0).
// RULE6 - A DAC output with a zero sync bit updates asynchronously without waiting for the common load.
// RULE7 - While closed-loop control is active the four main DACs are always asynchronous.
// RULE8 - Each aux DAC range bit selects 0 to 5 V when zero and 2.5 to 7.5 V when one (aux 4..1 at 7..4).
// RULE9 - A bipolar pair field gives 00 -4..1 V, 01 or 10 -5..0 V, 11 0..5 V (pair 3/4 at 3..2, 1/2 at 1..0).
// RULE10 - Bits 15..8 of the update-mode and span registers are reserved for factory use and reset to 0x00.
// RULE11 - Sync-mode DAC codes wait for a common load event and then all such outputs update together.
// RULE12 - Software writes zeros to reserved bits and preserves them on read-modify-write.
package cfgr_pkg;

  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned REG_WIDTH  = 16;
  localparam int unsigned CODE_WIDTH = 12;
  localparam int unsigned NUM_DACS   = 8;

  // Printed offsets are not all multiples of four: byte address is index times four
  localparam logic [7:0] IDX_CHANNEL_SELECT = 8'h12;
  localparam logic [7:0] IDX_LOOP_RAMP_TIME = 8'h14;
  localparam logic [7:0] IDX_DAC_UPDATE     = 8'h15;
  localparam logic [7:0] IDX_DAC_SPAN       = 8'h16;
  localparam logic [7:0] IDX_LOOP_STATUS    = 8'h1c;

  localparam logic [15:0] RST_CHANNEL_SELECT = 16'h0000;
  localparam logic [15:0] RST_LOOP_RAMP_TIME = 16'h2222;
  localparam logic [15:0] RST_DAC_UPDATE     = 16'h0000;
  localparam logic [15:0] RST_DAC_SPAN       = 16'h0000;
  localparam logic [3:0]  RST_RAMP_FIELD     = 4'h2;

  localparam logic [15:0] MASK_CHANNEL_SELECT = 16'h7fff;
  localparam logic [15:0] MASK_LOW_BYTE       = 16'h00ff;
  localparam logic [3:0]  RAMP_CODE_MAX       = 4'ha;

  localparam int unsigned RAMP_FIELD_WIDTH = 4;
  localparam int unsigned CHANNEL_COUNT    = 15;

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Settling time in microseconds per ramp code
  localparam int unsigned RAMP_TIME_US [0:10] = '{800, 1600, 2400, 3200, 4800, 6400, 9600, 12800, 19200, 25600,
                                                  28800};
  localparam int unsigned CLK_MHZ = 125;

  typedef struct packed {
    logic [3:0] ramp_time_four;
    logic [3:0] ramp_time_three;
    logic [3:0] ramp_time_two;
    logic [3:0] ramp_time_one;
  } cfgr_ramp_type;

  typedef struct packed {
    logic [3:0] aux_out_span;
    logic [1:0] bipolar_pair_b_span;
    logic [1:0] bipolar_pair_a_span;
  } cfgr_span_type;

  typedef struct packed {
    logic [7:0] factory;
    logic [3:0] aux_sync_mode;
    logic [3:0] main_sync_mode;
  } cfgr_update_type;

  typedef enum logic [2:0] {
    CFGR_RD_IDLE = 3'b001,
    CFGR_RD_DATA = 3'b010,
    CFGR_RD_WAIT = 3'b100
  } cfgr_rd_state_type;

  function automatic int unsigned cfgr_ramp_cycles(input logic [3:0] code);
    int unsigned us;
    us = (code <= RAMP_CODE_MAX) ? RAMP_TIME_US[code] : RAMP_TIME_US[0];
    return us * CLK_MHZ;
  endfunction : cfgr_ramp_cycles

endpackage : cfgr_pkg

// File: rtl/cfgr_dac_latch.sv
`timescale 1ns/1ns
// Per-output code holding: async outputs follow at once, sync ones wait for load
module cfgr_dac_latch
  import cfgr_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_DACS,
  parameter int unsigned WIDTH    = CODE_WIDTH
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic [CHANNELS-1:0]       i_sync_mode,
  input  wire logic [CHANNELS-1:0]       i_code_we,
  input  wire logic [CHANNELS*WIDTH-1:0] i_code,
  input  wire logic                      i_load,
  output logic      [CHANNELS*WIDTH-1:0] o_code,
  output logic      [CHANNELS-1:0]       o_pending
);

  logic [CHANNELS*WIDTH-1:0] held;

  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        held[g*WIDTH +: WIDTH] <= '0;
      end else if (i_code_we[g]) begin
        held[g*WIDTH +: WIDTH] <= i_code[g*WIDTH +: WIDTH];
      end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        o_pending[g] <= 1'b0;
      end else if (i_code_we[g] && i_sync_mode[g]) begin
        o_pending[g] <= 1'b1; // RULE11
      end else if (i_load || !i_sync_mode[g]) begin
        o_pending[g] <= 1'b0;
      end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        o_code[g*WIDTH +: WIDTH] <= '0;
      end else if (!i_sync_mode[g] && i_code_we[g]) begin
        o_code[g*WIDTH +: WIDTH] <= i_code[g*WIDTH +: WIDTH]; // RULE6
      end else if (!i_sync_mode[g] || i_load) begin
        o_code[g*WIDTH +: WIDTH] <= held[g*WIDTH +: WIDTH]; // RULE11
      end
    end
  end

endmodule : cfgr_dac_latch

// File: rtl/cfgr_regs.sv
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
module cfgr_regs
  import cfgr_pkg::*;
(
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst,
  // AXI4-Lite slave
  input  wire logic [ADDR_WIDTH-1:0]       i_awaddr,
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [DATA_WIDTH-1:0]       i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  output logic [1:0]                       o_bresp,
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  input  wire logic [ADDR_WIDTH-1:0]       i_araddr,
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  output logic [DATA_WIDTH-1:0]            o_rdata,
  output logic [1:0]                       o_rresp,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  // Block side
  input  wire logic                        i_loop_active,
  input  wire logic                        i_conv_start,
  input  wire logic [NUM_DACS-1:0]         i_code_we,
  input  wire logic [NUM_DACS*CODE_WIDTH-1:0] i_code,
  input  wire logic                        i_load,
  output logic [CHANNEL_COUNT-1:0]         o_conv_channels,
  output cfgr_ramp_type                    o_ramp_time,
  output logic [3:0]                       o_ramp_invalid,
  output logic [NUM_DACS-1:0]              o_sync_mode,
  output cfgr_span_type                    o_span,
  output logic [NUM_DACS*CODE_WIDTH-1:0]   o_dac_code
);

  logic [15:0]        channel_select;
  cfgr_ramp_type      loop_ramp_time;
  cfgr_update_type    dac_update_mode;
  logic [15:0]        dac_output_span;
  logic [NUM_DACS-1:0] next_sync_mode;
  logic [NUM_DACS-1:0] pending;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic [DATA_WIDTH-1:0] w_data;
  logic [3:0]         w_strb;
  logic               aw_held;
  logic               w_held;
  logic               do_write;
  logic [5:0]         wr_idx;
  logic [5:0]         rd_idx;
  logic [15:0]        wmask;
  cfgr_rd_state_type  rd_state;
  logic [ADDR_WIDTH-1:0] ar_addr;
  logic [15:0]        rd_value;
  logic               rd_hit;
  logic               wr_hit;

  // Write address and data are captured separately, in either order
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held   <= 1'b0;
      aw_addr   <= '0;
      o_awready <= 1'b1;
    end else if (o_awready && i_awvalid) begin
      aw_held   <= 1'b1;
      aw_addr   <= i_awaddr;
      o_awready <= 1'b0;
    end else if (do_write) begin
      aw_held   <= 1'b0;
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      w_held   <= 1'b0;
      w_data   <= '0;
      w_strb   <= '0;
      o_wready <= 1'b1;
    end else if (o_wready && i_wvalid) begin
      w_held   <= 1'b1;
      w_data   <= i_wdata;
      w_strb   <= i_wstrb;
      o_wready <= 1'b0;
    end else if (do_write) begin
      w_held   <= 1'b0;
      o_wready <= 1'b1;
    end
  end

  // One write in flight: hold both halves until the response is accepted
  assign do_write = aw_held && w_held && !o_bvalid;
  assign wr_idx   = aw_addr[7:2];
  assign wmask    = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  always_comb begin
    wr_hit = 1'b1;
    case ({2'b00, wr_idx})
      IDX_CHANNEL_SELECT, IDX_LOOP_RAMP_TIME, IDX_DAC_UPDATE, IDX_DAC_SPAN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= AXI_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      channel_select <= RST_CHANNEL_SELECT;
    end else if (do_write && {2'b00, wr_idx} == IDX_CHANNEL_SELECT) begin
      channel_select <= (channel_select & ~wmask) | (w_data[15:0] & wmask);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      loop_ramp_time <= RST_LOOP_RAMP_TIME; // RULE3
    end else if (do_write && {2'b00, wr_idx} == IDX_LOOP_RAMP_TIME) begin
      loop_ramp_time <= (loop_ramp_time & ~wmask) | (w_data[15:0] & wmask); // RULE3
    end
  end

  // Factory byte is stored so read-modify-write round-trips it
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      dac_update_mode <= RST_DAC_UPDATE; // RULE10
    end else if (do_write && {2'b00, wr_idx} == IDX_DAC_UPDATE) begin
      dac_update_mode <= (dac_update_mode & ~wmask) | (w_data[15:0] & wmask); // RULE5
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      dac_output_span <= RST_DAC_SPAN; // RULE10
    end else if (do_write && {2'b00, wr_idx} == IDX_DAC_SPAN) begin
      dac_output_span <= (dac_output_span & ~wmask) | (w_data[15:0] & wmask);
    end
  end

  // Read channel
  assign rd_idx = ar_addr[7:2];

  always_comb begin
    rd_value = 16'h0000;
    rd_hit   = 1'b1;
    case ({2'b00, rd_idx})
      IDX_CHANNEL_SELECT: rd_value = channel_select;
      IDX_LOOP_RAMP_TIME: rd_value = loop_ramp_time;
      IDX_DAC_UPDATE:     rd_value = dac_update_mode;
      IDX_DAC_SPAN:       rd_value = dac_output_span;
      IDX_LOOP_STATUS:    rd_value = {4'h0, o_ramp_invalid, pending};
      default:            rd_hit   = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_state  <= CFGR_RD_IDLE;
      ar_addr   <= '0;
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= AXI_OKAY;
    end else begin
      case (rd_state)
        CFGR_RD_IDLE: begin
          if (i_arvalid) begin
            ar_addr   <= i_araddr;
            o_arready <= 1'b0;
            rd_state  <= CFGR_RD_DATA;
          end
        end
        CFGR_RD_DATA: begin
          o_rdata  <= {16'h0000, rd_value};
          o_rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
          o_rvalid <= 1'b1;
          rd_state <= CFGR_RD_WAIT;
        end
        CFGR_RD_WAIT: begin
          if (i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
            rd_state  <= CFGR_RD_IDLE;
          end
        end
        default: rd_state <= CFGR_RD_IDLE;
      endcase
    end
  end

  // Effective update mode: main outputs forced async under closed-loop control
  always_comb begin
    next_sync_mode = {dac_update_mode.aux_sync_mode, dac_update_mode.main_sync_mode}; // RULE5
    if (i_loop_active) begin
      next_sync_mode[3:0] = 4'h0; // RULE7
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sync_mode <= '0;
    end else begin
      o_sync_mode <= next_sync_mode; // RULE6
    end
  end

  // Channel list sampled once per conversion cycle so a mid-cycle write cannot tear it
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_conv_channels <= '0;
    end else if (i_conv_start) begin
      o_conv_channels <= channel_select[CHANNEL_COUNT-1:0]; // RULE1 RULE2
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ramp_time <= RST_LOOP_RAMP_TIME;
      o_span      <= '0;
    end else begin
      o_ramp_time <= loop_ramp_time;
      o_span      <= dac_output_span[7:0]; // RULE8 RULE9
    end
  end

  // Codes above the table are flagged; the loop logic falls back to the shortest time
  for (genvar g = 0; g < 4; g++) begin : g_ramp
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        o_ramp_invalid[g] <= 1'b0;
      end else begin
        o_ramp_invalid[g] <= loop_ramp_time[g*RAMP_FIELD_WIDTH +: RAMP_FIELD_WIDTH] > RAMP_CODE_MAX; // RULE4
      end
    end
  end

  cfgr_dac_latch #(
    .CHANNELS (NUM_DACS),
    .WIDTH    (CODE_WIDTH)
  ) u_latch (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_sync_mode (o_sync_mode),
    .i_code_we   (i_code_we),
    .i_code      (i_code),
    .i_load      (i_load),
    .o_code      (o_dac_code),
    .o_pending   (pending)
  );

endmodule : cfgr_regs

// File: tb/cfgr_regs_properties.sv
`timescale 1ns/1ns
module cfgr_regs_properties
  import cfgr_pkg::*;
(
  input wire logic          i_sys_clk,
  input wire logic          i_rst,
  input wire logic [1:0]    o_bresp,
  input wire logic          o_bvalid,
  input wire logic          i_bready,
  input wire logic [31:0]   o_rdata,
  input wire logic          o_rvalid,
  input wire logic          i_rready,
  input wire logic          i_loop_active,
  input wire logic          i_conv_start,
  input wire logic [7:0]    i_code_we,
  input wire logic [95:0]   i_code,
  input wire logic          i_load,
  input wire logic [14:0]   o_conv_channels,
  input wire cfgr_ramp_type o_ramp_time,
  input wire logic [3:0]    o_ramp_invalid,
  input wire logic [7:0]    o_sync_mode,
  input wire logic [95:0]   o_dac_code
);
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  AST_CONV_HELD: assert property (!i_conv_start |=> $stable(o_conv_channels))
    else $error("channel bitmap moved without a conversion start");
  AST_LOOP_ASYNC: assert property (i_loop_active |=> o_sync_mode[3:0] == 4'h0)
    else $error("main outputs not asynchronous in closed loop");
  AST_RAMP_BAD: assert property ($stable(o_ramp_time) [*2] |-> o_ramp_invalid ==
    {o_ramp_time[15:12] > 4'ha, o_ramp_time[11:8] > 4'ha, o_ramp_time[7:4] > 4'ha, o_ramp_time[3:0] > 4'ha})
    else $error("ramp invalid flags disagree with ramp fields");
  AST_ASYNC_CODE: assert property (i_code_we[7] && !o_sync_mode[7] && !$past(o_sync_mode[7])
    |=> o_dac_code[95:84] == $past(i_code[95:84])) else $error("async code not passed through");
  AST_SYNC_HELD: assert property (o_sync_mode[7] && !i_load |=>
    $stable(o_dac_code[95:84]) || !o_sync_mode[7]) else $error("sync code changed without load");
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  AST_R_UPPER: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  cover property (i_load && o_sync_mode[7]);
  cover property (i_conv_start);
  cover property (o_bvalid && o_bresp == AXI_SLVERR);
endmodule : cfgr_regs_properties

bind cfgr_regs cfgr_regs_properties u_props (.i_sys_clk, .i_rst, .o_bresp, .o_bvalid, .i_bready, .o_rdata,
  .o_rvalid, .i_rready, .i_loop_active, .i_conv_start, .i_code_we, .i_code, .i_load, .o_conv_channels,
  .o_ramp_time, .o_ramp_invalid, .o_sync_mode, .o_dac_code);

// File: tb/tb_adc_dac_config_registers.sv
`timescale 1ns/1ns
module tb_adc_dac_config_registers;
  import cfgr_pkg::*;
  logic i_sys_clk = 0, i_rst = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic i_loop_active = 0, i_conv_start = 0, i_load = 0;
  logic [7:0] i_awaddr = 0, i_araddr = 0, i_code_we = 0;
  logic [31:0] i_wdata = 0;
  logic [3:0] i_wstrb = 0;
  logic [95:0] i_code = 0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [14:0] o_conv_channels;
  cfgr_ramp_type o_ramp_time;
  logic [3:0] o_ramp_invalid;
  logic [7:0] o_sync_mode;
  cfgr_span_type o_span;
  logic [95:0] o_dac_code;
  int num_errors = 0;
  int n_checks = 0;

  cfgr_regs dut (.i_sys_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .i_loop_active, .i_conv_start, .i_code_we, .i_code, .i_load, .o_conv_channels,
    .o_ramp_time, .o_ramp_invalid, .o_sync_mode, .o_span, .o_dac_code);

  initial begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc

  // Ready is raised only after valid is seen, so the hold-while-stalled path is exercised
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = AXI_OKAY,
                    input logic [3:0] st = 4'hf);
    @(posedge i_sys_clk);
    i_awaddr <= idx << 2;
    i_wdata <= d;
    i_wstrb <= st;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    forever begin
      @(posedge i_sys_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid && i_bready) begin
        chk(o_bresp, er);
        i_bready <= 1'b0;
        break;
      end
      if (o_bvalid) i_bready <= 1'b1;
    end
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er = AXI_OKAY);
    @(posedge i_sys_clk);
    i_araddr <= idx << 2;
    i_arvalid <= 1'b1;
    forever begin
      @(posedge i_sys_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid && i_rready) begin
        chk(o_rdata, e);
        chk(o_rresp, er);
        i_rready <= 1'b0;
        break;
      end
      if (o_rvalid) i_rready <= 1'b1;
    end
  endtask : rd

  task automatic conv_pulse;
    i_conv_start <= 1'b1;
    cyc(1);
    i_conv_start <= 1'b0;
    cyc(3);
  endtask : conv_pulse

  task automatic t_reset;
    rd(IDX_CHANNEL_SELECT, 32'h0);
    rd(IDX_LOOP_RAMP_TIME, 32'h2222);
    rd(IDX_DAC_UPDATE, 32'h0);
    rd(IDX_DAC_SPAN, 32'h0);
    chk(o_ramp_time, 16'h2222);
    wr(8'h17, 32'h1, AXI_SLVERR);
    rd(8'h17, 32'h0, AXI_SLVERR);
    wr(IDX_LOOP_STATUS, 32'h1, AXI_SLVERR);
    wr(IDX_DAC_UPDATE, 32'h1234a500);
    rd(IDX_DAC_UPDATE, 32'h0000a500);
  endtask : t_reset

  task automatic t_ramp;
    for (int c = 0; c < 16; c++) begin
      wr(IDX_LOOP_RAMP_TIME, {16'h0, {4{c[3:0]}}});
      cyc(3);
      chk(o_ramp_invalid, (c > 10) ? 4'hf : 4'h0);
    end
    wr(IDX_LOOP_RAMP_TIME, 32'hb0a1);
    cyc(3);
    chk(o_ramp_time, 16'hb0a1);
    chk(o_ramp_invalid, 4'h8);
  endtask : t_ramp

  task automatic t_conv;
    wr(IDX_CHANNEL_SELECT, 32'h5a5a);
    cyc(3);
    chk(o_conv_channels, 15'h0);
    conv_pulse();
    chk(o_conv_channels, 15'h5a5a);
    wr(IDX_CHANNEL_SELECT, 32'h8001);
    rd(IDX_CHANNEL_SELECT, 32'h8001);
    conv_pulse();
    chk(o_conv_channels, 15'h0001);
  endtask : t_conv

  task automatic t_span;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_DAC_SPAN, {24'h0, 4'h5, i[1:0], ~i[1:0]});
      cyc(2);
      chk(o_span, {4'h5, i[1:0], ~i[1:0]});
    end
    wr(IDX_DAC_SPAN, 32'hc3a0);
    rd(IDX_DAC_SPAN, 32'hc3a0);
    chk(o_span, 8'ha0);
    // Read-modify-write hands the factory byte back exactly as it was read
    wr(IDX_DAC_SPAN, 32'hc35f);
    rd(IDX_DAC_SPAN, 32'hc35f);
    // Only lane 0 strobed: the factory byte must not pick up the zero in lane 1
    wr(IDX_DAC_SPAN, 32'hffff0011, AXI_OKAY, 4'h1);
    rd(IDX_DAC_SPAN, 32'hc311);
  endtask : t_span

  task automatic t_dac;
    wr(IDX_DAC_UPDATE, 32'h0);
    cyc(3);
    i_code[95:84] <= 12'h111;
    i_code_we <= 8'h80;
    cyc(1);
    i_code_we <= 8'h00;
    cyc(2);
    chk(o_dac_code[95:84], 12'h111);
    wr(IDX_DAC_UPDATE, 32'h81);
    cyc(3);
    chk(o_sync_mode, 8'h81);
    i_code[95:84] <= 12'habc;
    i_code[23:0] <= 24'h123456;
    i_code_we <= 8'h83;
    cyc(1);
    i_code_we <= 8'h00;
    cyc(2);
    chk(o_dac_code[23:12], 12'h123);
    chk(o_dac_code[95:84], 12'h111);
    chk(o_dac_code[11:0], 12'h000);
    // Status: loop 4 still holds code b from the ramp scenario, outputs 8 and 1 wait for load
    rd(IDX_LOOP_STATUS, 32'h0881);
    i_load <= 1'b1;
    cyc(1);
    i_load <= 1'b0;
    cyc(2);
    chk({o_dac_code[95:84], o_dac_code[11:0]}, 24'habc456);
    rd(IDX_LOOP_STATUS, 32'h0800);
    wr(IDX_DAC_UPDATE, 32'h0f);
    i_loop_active <= 1'b1;
    cyc(3);
    chk(o_sync_mode, 8'h00);
    i_code[35:24] <= 12'h789;
    i_code_we <= 8'h04;
    cyc(1);
    i_code_we <= 8'h00;
    cyc(2);
    chk(o_dac_code[35:24], 12'h789);
    i_loop_active <= 1'b0;
    cyc(3);
    chk(o_sync_mode, 8'h0f);
  endtask : t_dac

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    cyc(5);
    i_rst <= 1'b0;
    t_reset();
    t_ramp();
    t_conv();
    t_span();
    t_dac();
    end_of_test();
  end

  // Whole run is well under 2000 cycles; this limit leaves ample margin
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
endmodule : tb_adc_dac_config_registers
